/* design/pwm_dac_top.sv */
// Summary of operation
// - Clock select 0 runs the generator at clock/2 (16384-clock period), 1 at clock/4 (32768-clock period).
// - The clock select register resets to FE and its seven upper bits read 1 and ignore writes.
// - The clock select bit is write-only and always reads back as 1.
// - The duty is 14 bits: upper 6 in bits 5..0 of the upper byte, lower 8 in the lower byte.
// - Up to a duty of 3FC0, high time per period equals (duty + 64) times half the generator input clock period.
// - Writing the upper byte hands the full 14-bit value to the generator, applied in step with its timing.
// - Both duty bytes are write-only and read as all ones.
// - The duty bytes reset to C000: upper C0 with top bits 1, lower 00.
// - Each period is split into 64 equal slots with the high time spread among them.
// - A duty from 3FC0 to 3FFF keeps the output high all the time.
module pwm_dac_top
    import pwm_dac_pkg::*;
#(
    parameter int PERIOD_FAST_CLKS = PERIOD_DIV2_CLKS,
    parameter int PERIOD_SLOW_CLKS = PERIOD_DIV4_CLKS
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [DATA_W-1:0] s_axi_wdata,
    input wire logic [DATA_W/8-1:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [DATA_W-1:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic pwm_out
);

    // map a byte address to a register
    function automatic reg_sel_e reg_decode(input logic [ADDR_W-1:0] addr);
        reg_sel_e sel;
        sel = SEL_NONE;
        if (addr[1:0] == 2'h0) begin
            unique case (addr[ADDR_W-1:2])
                CLOCK_SELECT_IDX: sel = SEL_CLOCK;
                DUTY_UPPER_IDX: sel = SEL_UPPER;
                DUTY_LOWER_IDX: sel = SEL_LOWER;
                STATUS_IDX: sel = SEL_STATUS;
                default: sel = SEL_NONE;
            endcase
        end
        return sel;
    endfunction : reg_decode

    logic aw_full_reg;
    logic [ADDR_W-1:0] aw_addr_reg;
    logic w_full_reg;
    logic [DATA_W-1:0] w_data_reg;
    logic [DATA_W/8-1:0] w_strb_reg;
    logic bvalid_reg;
    logic [1:0] bresp_reg;
    logic rvalid_reg;
    logic [1:0] rresp_reg;
    logic [DATA_W-1:0] rdata_reg;
    logic [DATA_W-1:0] rdata_next;
    reg_sel_e rd_sel_reg;
    reg_sel_e wr_sel;
    reg_sel_e rd_sel;
    logic wr_fire;
    logic wr_lane0;
    logic ar_fire;

    logic [7:0] clock_select_reg;
    logic [7:0] duty_upper_byte;
    logic [7:0] duty_lower_byte;
    logic [DUTY_W-1:0] latched_duty_reg;
    gen_cfg_s gen_cfg;
    gen_cfg_s gen_active;
    logic gen_period_start;
    logic gen_out;

    // channel readiness: one write and one read in flight
    assign s_axi_awready = !aw_full_reg && !bvalid_reg;
    assign s_axi_wready = !w_full_reg && !bvalid_reg;
    assign s_axi_arready = !rvalid_reg;
    assign wr_fire = aw_full_reg && w_full_reg && !bvalid_reg;
    assign ar_fire = s_axi_arvalid && s_axi_arready;
    assign wr_sel = reg_decode(aw_addr_reg);
    assign rd_sel = reg_decode(s_axi_araddr);
    assign wr_lane0 = wr_fire && w_strb_reg[0];

    // write address holding stage
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_full_reg <= 1'b0;
            aw_addr_reg <= '0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_full_reg <= 1'b1;
            aw_addr_reg <= s_axi_awaddr;
        end else if (wr_fire) begin
            aw_full_reg <= 1'b0;
        end
    end

    // write data holding stage
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_full_reg <= 1'b0;
            w_data_reg <= '0;
            w_strb_reg <= '0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_full_reg <= 1'b1;
            w_data_reg <= s_axi_wdata;
            w_strb_reg <= s_axi_wstrb;
        end else if (wr_fire) begin
            w_full_reg <= 1'b0;
        end
    end

    // write response once both halves are in
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_reg <= 1'b0;
            bresp_reg <= RESP_OKAY;
        end else if (wr_fire) begin
            bvalid_reg <= 1'b1;
            bresp_reg <= (wr_sel == SEL_NONE) ? RESP_DECERR : RESP_OKAY;
        end else if (s_axi_bready) begin
            bvalid_reg <= 1'b0;
        end
    end

    // clock select: only bit 0 is stored, the rest stay 1
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            clock_select_reg <= CLOCK_SELECT_RESET;
        end else if (wr_lane0 && wr_sel == SEL_CLOCK) begin
            clock_select_reg <= {CLOCK_SELECT_RESET[7:1], w_data_reg[PERIOD_SEL_BIT]};
        end
    end

    // lower duty byte, held until the upper byte arrives
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            duty_lower_byte <= DUTY_LOWER_RESET;
        end else if (wr_lane0 && wr_sel == SEL_LOWER) begin
            duty_lower_byte <= w_data_reg[DUTY_LOWER_W-1:0];
        end
    end

    // upper duty byte; top two bits always 1
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            duty_upper_byte <= DUTY_UPPER_RESET;
        end else if (wr_lane0 && wr_sel == SEL_UPPER) begin
            duty_upper_byte <= {DUTY_UPPER_UNUSED, w_data_reg[DUTY_UPPER_W-1:0]};
        end
    end

    // upper byte write transfers the whole 14-bit value
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            latched_duty_reg <= {DUTY_UPPER_RESET[DUTY_UPPER_W-1:0], DUTY_LOWER_RESET};
        end else if (wr_lane0 && wr_sel == SEL_UPPER) begin
            latched_duty_reg <= {w_data_reg[DUTY_UPPER_W-1:0], duty_lower_byte};
        end
    end

    assign gen_cfg.period_sel = clock_select_reg[PERIOD_SEL_BIT];
    assign gen_cfg.duty = latched_duty_reg;

    // read image: write-only registers answer all ones
    always_comb begin
        rdata_next = '0;
        unique case (rd_sel)
            SEL_CLOCK: rdata_next = {24'h000000, WRITE_ONLY_READ};
            SEL_UPPER: rdata_next = {24'h000000, WRITE_ONLY_READ};
            SEL_LOWER: rdata_next = {24'h000000, WRITE_ONLY_READ};
            SEL_STATUS: begin
                rdata_next[DUTY_W-1:0] = gen_active.duty;
                rdata_next[STATUS_SEL_BIT] = gen_active.period_sel;
                rdata_next[STATUS_OUT_BIT] = gen_out;
            end
            SEL_NONE: rdata_next = '0;
        endcase
    end

    // read channel
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_reg <= 1'b0;
            rresp_reg <= RESP_OKAY;
            rdata_reg <= '0;
            rd_sel_reg <= SEL_NONE;
        end else if (ar_fire) begin
            rvalid_reg <= 1'b1;
            rresp_reg <= (rd_sel == SEL_NONE) ? RESP_DECERR : RESP_OKAY;
            rdata_reg <= rdata_next;
            rd_sel_reg <= rd_sel;
        end else if (s_axi_rready) begin
            rvalid_reg <= 1'b0;
        end
    end

    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp = bresp_reg;
    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rresp = rresp_reg;
    assign s_axi_rdata = rdata_reg;
    assign pwm_out = gen_out;

    // waveform generator
    pwm_wave_gen #(
        .PERIOD_FAST_CLKS(PERIOD_FAST_CLKS),
        .PERIOD_SLOW_CLKS(PERIOD_SLOW_CLKS)
    ) u_gen (
        .aclk(aclk),
        .aresetn(aresetn),
        .cfg(gen_cfg),
        .active(gen_active),
        .period_start(gen_period_start),
        .pwm_out(gen_out)
    );

    // checks on the register side
    sequence s_upper_write;
        wr_lane0 && wr_sel == SEL_UPPER;
    endsequence

    sequence s_lower_write;
        wr_lane0 && wr_sel == SEL_LOWER;
    endsequence

    AST_CLOCK_READ_ONES: assert property (@(posedge aclk) disable iff (!aresetn)
        rvalid_reg && rd_sel_reg == SEL_CLOCK |-> rdata_reg == 32'h000000FF)
        else $error("clock select read not all ones");

    AST_DUTY_READ_ONES: assert property (@(posedge aclk) disable iff (!aresetn)
        rvalid_reg && (rd_sel_reg == SEL_UPPER || rd_sel_reg == SEL_LOWER) |-> rdata_reg == 32'h000000FF)
        else $error("duty read not all ones");

    AST_RESERVED_HIGH: assert property (@(posedge aclk) disable iff (!aresetn)
        1'b1 |-> clock_select_reg[7:1] == CLOCK_SELECT_RESET[7:1])
        else $error("reserved clock select bits not 1");

    AST_RESET_VALUES: assert property (@(posedge aclk)
        !aresetn |=> clock_select_reg == CLOCK_SELECT_RESET && duty_upper_byte == DUTY_UPPER_RESET
            && duty_lower_byte == DUTY_LOWER_RESET && latched_duty_reg == 14'h0000)
        else $error("reset values wrong");

    AST_UPPER_TRANSFER: assert property (@(posedge aclk) disable iff (!aresetn)
        s_upper_write |=> latched_duty_reg == {$past(w_data_reg[5:0]), duty_lower_byte} && bvalid_reg)
        else $error("upper write did not transfer duty");

    AST_LOWER_HELD: assert property (@(posedge aclk) disable iff (!aresetn)
        s_lower_write ##1 !(wr_lane0 && wr_sel == SEL_UPPER) |=> $stable(latched_duty_reg))
        else $error("lower write reached the generator");

    AST_APPLY_AT_BOUNDARY: assert property (@(posedge aclk) disable iff (!aresetn)
        gen_period_start |=> gen_active == $past(gen_cfg))
        else $error("generator did not take new settings at boundary");

endmodule : pwm_dac_top

/* design/pwm_dac_pkg.sv */
package pwm_dac_pkg;

    // bus geometry
    localparam int ADDR_W = 18;
    localparam int DATA_W = 32;

    // register indices; byte address is four times the index
    localparam logic [15:0] CLOCK_SELECT_IDX = 16'hFFCC;
    localparam logic [15:0] DUTY_UPPER_IDX = 16'hFFCD;
    localparam logic [15:0] DUTY_LOWER_IDX = 16'hFFCE;
    localparam logic [15:0] STATUS_IDX = 16'hFFCF;

    // reset values and read images
    localparam logic [7:0] CLOCK_SELECT_RESET = 8'hFE;
    localparam logic [7:0] DUTY_UPPER_RESET = 8'hC0;
    localparam logic [7:0] DUTY_LOWER_RESET = 8'h00;
    localparam logic [7:0] WRITE_ONLY_READ = 8'hFF;
    localparam logic [1:0] DUTY_UPPER_UNUSED = 2'h3;

    // field layout
    localparam int PERIOD_SEL_BIT = 0;
    localparam int DUTY_W = 14;
    localparam int DUTY_UPPER_W = 6;
    localparam int DUTY_LOWER_W = 8;
    localparam int SLOT_BITS = 6;
    localparam int UNIT_BITS = 8;
    localparam logic [DUTY_W-1:0] DUTY_FULL_HIGH = 14'h3FC0;
    localparam int DUTY_OFFSET = 64;

    // status register fields
    localparam int STATUS_SEL_BIT = 14;
    localparam int STATUS_OUT_BIT = 15;

    // conversion periods in system clocks
    localparam int PERIOD_DIV2_CLKS = 16384;
    localparam int PERIOD_DIV4_CLKS = 32768;

    // bus responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_DECERR = 2'h3;

    typedef enum logic [2:0] {
        SEL_CLOCK,
        SEL_UPPER,
        SEL_LOWER,
        SEL_STATUS,
        SEL_NONE
    } reg_sel_e;

    // configuration handed to the waveform generator
    typedef struct packed {
        logic period_sel;
        logic [DUTY_W-1:0] duty;
    } gen_cfg_s;

    // slot order for spreading the spare units evenly
    function automatic logic [SLOT_BITS-1:0] bit_reverse(input logic [SLOT_BITS-1:0] v);
        logic [SLOT_BITS-1:0] r;
        r = '0;
        for (int i = 0; i < SLOT_BITS; i++) begin
            r[i] = v[SLOT_BITS-1-i];
        end
        return r;
    endfunction : bit_reverse

endpackage : pwm_dac_pkg

/* design/pwm_wave_gen.sv */
module pwm_wave_gen
    import pwm_dac_pkg::*;
#(
    parameter int PERIOD_FAST_CLKS = PERIOD_DIV2_CLKS,
    parameter int PERIOD_SLOW_CLKS = PERIOD_DIV4_CLKS
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire gen_cfg_s cfg,
    output gen_cfg_s active,
    output logic period_start,
    output logic pwm_out
);

    logic half_reg;
    logic [UNIT_BITS+SLOT_BITS-1:0] pos_reg;
    gen_cfg_s active_reg;
    logic pwm_reg;
    logic unit_tick;
    logic wrap;
    logic [UNIT_BITS:0] slot_high;
    logic high;

    // unit tick: every clock for div 2, every other clock for div 4
    assign unit_tick = !active_reg.period_sel || half_reg;
    assign wrap = unit_tick && (&pos_reg);

    // per slot: upper duty bits plus one, one spare unit in slots whose bit-reversed number is below the low six duty bits
    assign slot_high = {1'b0, active_reg.duty[DUTY_W-1:SLOT_BITS]} + 9'h001
        + {8'h00, (bit_reverse(pos_reg[UNIT_BITS+SLOT_BITS-1:UNIT_BITS]) < active_reg.duty[SLOT_BITS-1:0])};
    // saturates to a full slot from 3FC0 upward
    assign high = {1'b0, pos_reg[UNIT_BITS-1:0]} < slot_high;

    // input clock divider
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            half_reg <= 1'b0;
        end else begin
            half_reg <= active_reg.period_sel ? !half_reg : 1'b0;
        end
    end

    // position in the period: slot in upper bits, unit in lower
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pos_reg <= '0;
        end else if (unit_tick) begin
            pos_reg <= pos_reg + 14'h0001;
        end
    end

    // new settings only at a period boundary
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            active_reg <= '0;
        end else if (wrap) begin
            active_reg <= cfg;
        end
    end

    // registered output
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pwm_reg <= 1'b0;
        end else begin
            pwm_reg <= high;
        end
    end

    assign active = active_reg;
    assign period_start = wrap;
    assign pwm_out = pwm_reg;

    // helper counters for checks
    logic [16:0] chk_cycles;
    logic [16:0] chk_high;
    always_ff @(posedge aclk) begin
        if (!aresetn || wrap) begin
            chk_cycles <= '0;
            chk_high <= '0;
        end else begin
            chk_cycles <= chk_cycles + 17'h00001;
            chk_high <= chk_high + {16'h0000, high};
        end
    end

    AST_PERIOD_LEN: assert property (@(posedge aclk) disable iff (!aresetn)
        wrap |-> (32'(chk_cycles) + 1 == (active_reg.period_sel ? PERIOD_SLOW_CLKS : PERIOD_FAST_CLKS)))
        else $error("conversion period length wrong");

    AST_HIGH_TIME: assert property (@(posedge aclk) disable iff (!aresetn)
        wrap && active_reg.duty < DUTY_FULL_HIGH |-> (32'(chk_high) + 32'(high)
            == (32'(active_reg.duty) + DUTY_OFFSET) * (active_reg.period_sel ? 2 : 1)))
        else $error("total high time wrong");

    AST_FULL_HIGH: assert property (@(posedge aclk) disable iff (!aresetn)
        active_reg.duty >= DUTY_FULL_HIGH |=> pwm_out)
        else $error("output not held high");

    AST_SLOT_START: assert property (@(posedge aclk) disable iff (!aresetn)
        pos_reg[UNIT_BITS-1:0] == '0 |=> pwm_out)
        else $error("slot does not open with a pulse");

    AST_SLOW_TICK: assert property (@(posedge aclk) disable iff (!aresetn)
        active_reg.period_sel && unit_tick && !wrap |=> !unit_tick ##1 unit_tick)
        else $error("divide by four rate wrong");

    AST_HOLD_MID: assert property (@(posedge aclk) disable iff (!aresetn)
        !wrap |=> $stable(active_reg))
        else $error("settings changed inside a period");

endmodule : pwm_wave_gen

/* test/lp_filter_model.sv */
module lp_filter_model (
    input wire logic aclk,
    input wire logic clear,
    input wire logic pwm_in,
    output logic [16:0] high_cnt,
    output logic [7:0] rise_cnt
);
    timeunit 1ns;
    timeprecision 100ps;

    logic last_level;

    // integrate high time and count pulses since the last clear
    always_ff @(posedge aclk) begin
        last_level <= pwm_in;
        high_cnt <= clear ? '0 : high_cnt + 17'(pwm_in);
        rise_cnt <= clear ? '0 : rise_cnt + 8'(pwm_in && !last_level);
    end
endmodule : lp_filter_model

/* test/tb_top.sv */
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin miscompares++; \
    $display("unexpected %s exp %0h got %0h", n, e, g); end end

module tb_top import pwm_dac_pkg::*;;
    timeunit 1ns;
    timeprecision 100ps;

    typedef struct packed {
        logic sel;
        logic [DUTY_W-1:0] duty;
        logic [16:0] win;
        logic [16:0] high;
        logic [7:0] rise;
    } row_s;

    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic clear = 1'b0;
    logic [ADDR_W-1:0] s_axi_awaddr = '0;
    logic [ADDR_W-1:0] s_axi_araddr = '0;
    logic [2:0] s_axi_awprot = '0;
    logic [2:0] s_axi_arprot = '0;
    logic [DATA_W-1:0] s_axi_wdata = '0;
    logic [DATA_W-1:0] s_axi_rdata;
    logic [DATA_W/8-1:0] s_axi_wstrb = 4'hF;
    logic s_axi_awvalid = 1'b0;
    logic s_axi_wvalid = 1'b0;
    logic s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0;
    logic s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, pwm_out;
    logic [1:0] s_axi_bresp, s_axi_rresp, r;
    logic [31:0] d;
    logic [14:0] prev;
    logic [16:0] high_cnt;
    logic [7:0] rise_cnt;
    int miscompares = 0;
    int checks_done = 0;
    row_s rows[3];

    always #2 aclk = ~aclk;

    pwm_dac_top dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .pwm_out);

    lp_filter_model filt (.aclk, .clear, .pwm_in(pwm_out), .high_cnt, .rise_cnt);

    // verdict and end of run
    task automatic test_done();
        if (miscompares == 0 && checks_done > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : test_done

    // one register write, address and data offered together
    task automatic wr(input logic [15:0] idx, input logic [7:0] val, output logic [1:0] resp);
        logic done = 1'b0;
        @(posedge aclk);
        s_axi_awaddr <= {idx, 2'b00};
        s_axi_wdata <= {24'h000000, val};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (int n = 0; n < 64 && !done; n++) begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) begin
                resp = s_axi_bresp;
                s_axi_bready <= 1'b0;
                done = 1'b1;
            end
        end
        if (!done) begin
            miscompares++;
            test_done();
        end
    endtask : wr

    // one register read
    task automatic rd(input logic [15:0] idx, output logic [31:0] data, output logic [1:0] resp);
        logic done = 1'b0;
        @(posedge aclk);
        s_axi_araddr <= {idx, 2'b00};
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (int n = 0; n < 64 && !done; n++) begin
            @(posedge aclk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) begin
                data = s_axi_rdata;
                resp = s_axi_rresp;
                s_axi_rready <= 1'b0;
                done = 1'b1;
            end
        end
        if (!done) begin
            miscompares++;
            test_done();
        end
    endtask : rd

    // poll the status view until the generator runs the wanted setting
    task automatic wait_active(input logic [14:0] want);
        logic done = 1'b0;
        for (int n = 0; n < 12000 && !done; n++) begin
            rd(STATUS_IDX, d, r);
            done = (d[14:0] === want);
        end
        if (!done) begin
            miscompares++;
            test_done();
        end
    endtask : wait_active

    initial begin
        rows[0] = '{1'b0, 14'h1234, 17'(PERIOD_DIV2_CLKS), 17'h1234 + 17'(DUTY_OFFSET), 8'd64};
        rows[1] = '{1'b0, 14'h3FC5, 17'd4096, 17'd4096, 8'd0};
        rows[2] = '{1'b1, 14'h0081, 17'(PERIOD_DIV4_CLKS), 17'd2 * (17'h0081 + 17'(DUTY_OFFSET)), 8'd64};
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        // read images of the write-only registers
        for (int i = 0; i < 3; i++) begin
            rd(16'(CLOCK_SELECT_IDX + 16'(i)), d, r);
            `CHK("read image", 32'h000000FF, d);
        end
        rd(STATUS_IDX, d, r);
        `CHK("status after reset", 32'h00000000, d & 32'h00007FFF);
        wr(CLOCK_SELECT_IDX, 8'h00, r);
        rd(CLOCK_SELECT_IDX, d, r);
        `CHK("clock select image", 32'h000000FF, d);
        wr(16'hFFD0, 8'h12, r);
        `CHK("unmapped bresp", RESP_DECERR, r);
        rd(16'hFFD0, d, r);
        `CHK("unmapped rresp", RESP_DECERR, r);
        prev = '0;
        // table of settings: measured high time and pulse count over one period, or over 4096 clocks for the 3FC5 row
        foreach (rows[i]) begin
            wr(CLOCK_SELECT_IDX, {7'h7F, rows[i].sel}, r);
            wr(DUTY_LOWER_IDX, rows[i].duty[7:0], r);
            wr(DUTY_UPPER_IDX, {2'b00, rows[i].duty[13:8]}, r);
            `CHK("duty bresp", RESP_OKAY, r);
            rd(STATUS_IDX, d, r);
            `CHK("mid period setting", prev, d[14:0]);
            wait_active({rows[i].sel, rows[i].duty});
            @(posedge aclk) clear <= 1'b1;
            @(posedge aclk) clear <= 1'b0;
            repeat (rows[i].win) @(posedge aclk);
            #1;
            `CHK("high time", rows[i].high, high_cnt);
            `CHK("pulse count", rows[i].rise, rise_cnt);
            prev = {rows[i].sel, rows[i].duty};
        end
        // second reset in mid-run
        @(posedge aclk) aresetn <= 1'b0;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        rd(STATUS_IDX, d, r);
        `CHK("status after second reset", 32'h00000000, d & 32'h00007FFF);
        test_done();
    end
endmodule : tb_top
